// file: rtl/touch_probe_detector_cfg.svh
`ifndef TOUCH_PROBE_DETECTOR_CFG_SVH
`define TOUCH_PROBE_DETECTOR_CFG_SVH

// clock and timebase
`define CLK_HZ          32'h02FA_F080
`define TICK_HZ         32'h0000_03E8

// intervals in milliseconds
`define SETTLE_MS       16'h01F4
`define CONTACT_WIN_MS  16'h03E8
`define FREE_WIN_MS     16'h03E8
`define ARM_TIMEOUT_MS  16'hEA60
`define LOWBAT_MS       16'h2710
`define NOCONTACT_MS    16'h2710
`define CRASH_MS        16'h2710
`define SLOW_HALF_MS    16'h01F4

// flash patterns and touch sample count
`define POOR_HALVES     4'hA
`define FLICKER_BIT     6
`define TOUCH_COUNT     2'h2

// sample levels, unsigned 10-bit codes
`define CODE_FULL       10'h3FF
`define CODE_ZERO       10'h000
`define OPEN_LEVEL      10'h3F0
`define POOR_MAX        10'h0C8
`define MIN_SEP         10'h004

`endif

// file: rtl/touch_probe_pkg.sv
package touch_probe_pkg;

  typedef logic [9:0] code_t;

  typedef enum logic [3:0] {
    ST_SETTLE,
    ST_LEARN_C,
    ST_LEARN_F,
    ST_ARMED,
    ST_CRASH,
    ST_LOWBAT,
    ST_NOCONTACT,
    ST_POOR,
    ST_OFF
  } state_t;

endpackage : touch_probe_pkg

// file: rtl/tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "touch_probe_detector_cfg.svh"

module tick_gen #(
  parameter int TICK_CYCLES = `CLK_HZ / `TICK_HZ
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // one-cycle strobe per tick
  output logic      tick
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        wrap;

  assign wrap = (cnt_r == 16'(TICK_CYCLES - 1));
  assign tick = wrap;

  always_comb begin
    cnt_nxt = wrap ? 16'h0000 : cnt_r + 16'h0001;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : tick_gen
`default_nettype wire

// file: rtl/touch_probe_detector.sv
`timescale 1ns/100ps
`default_nettype none
`include "touch_probe_detector_cfg.svh"

// Operation
// - wait half a second after power-up before taking any sample
// - bridge on: track minimum, store as contact reference, then green off
// - bridge off: track maximum, store as free reference, compute threshold
// - threshold computed: green steady to show armed
// - armed, two consecutive samples below threshold: red and touch output on
// - sample above threshold again: red and touch output off
// - power down one minute after first touch unless stay-awake input held
// - no touch one minute after arming: alternate colours, touch out, power down
// - low battery at power-up: slow red/green alternation ten seconds, then off
// - poor contact on bridge reading: five slow red flashes, then off
// - free reading too close to contact reference: flicker green
// - no valid contact in first second: flicker green, off after ten seconds
// - probe-present output asserted while powered
// - samples are unsigned 10-bit codes; compared with fixed levels and with the learned references
module touch_probe_detector
  import touch_probe_pkg::*;
#(
  parameter int          TICK_CYCLES    = `CLK_HZ / `TICK_HZ,
  parameter logic [15:0] SETTLE_MS      = `SETTLE_MS,
  parameter logic [15:0] CONTACT_WIN_MS = `CONTACT_WIN_MS,
  parameter logic [15:0] FREE_WIN_MS    = `FREE_WIN_MS,
  parameter logic [15:0] ARM_TIMEOUT_MS = `ARM_TIMEOUT_MS,
  parameter logic [15:0] LOWBAT_MS      = `LOWBAT_MS,
  parameter logic [15:0] NOCONTACT_MS   = `NOCONTACT_MS,
  parameter logic [15:0] CRASH_MS       = `CRASH_MS,
  parameter logic [15:0] SLOW_HALF_MS   = `SLOW_HALF_MS
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // converter
  output logic                       sample_req,
  input  wire touch_probe_pkg::code_t sample_code,
  input  wire logic                  sample_valid,
  // pins
  input  wire logic                  batt_low,
  input  wire logic                  stay_awake,
  // indicator and controller
  output logic                       led_red,
  output logic                       led_green,
  output logic                       touch_out,
  output logic                       probe_present,
  output logic                       power_hold
);

  import touch_probe_pkg::*;

  function automatic code_t mid_code(input code_t a, input code_t b);
    logic [10:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[10:1];
  endfunction : mid_code

  logic ms_tick;

  tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (ms_tick)
  );

  // pin synchronisers
  logic batt_meta_r;
  logic batt_s_r;
  logic stay_meta_r;
  logic stay_s_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      batt_meta_r <= 1'b0;
      batt_s_r    <= 1'b0;
      stay_meta_r <= 1'b0;
      stay_s_r    <= 1'b0;
    end else begin
      batt_meta_r <= batt_low;
      batt_s_r    <= batt_meta_r;
      stay_meta_r <= stay_awake;
      stay_s_r    <= stay_meta_r;
    end
  end

  // sequencer state
  state_t      state_r, state_nxt;
  logic [15:0] tm_r, tm_nxt;
  logic [15:0] bl_r, bl_nxt;
  logic        ph_r, ph_nxt;
  logic [3:0]  hc_r, hc_nxt;
  code_t       min_r, min_nxt;
  code_t       max_r, max_nxt;
  code_t       cref_r, cref_nxt;
  code_t       fref_r, fref_nxt;
  code_t       thr_r, thr_nxt;
  logic        seen_r, seen_nxt;
  logic        retry_r, retry_nxt;
  logic [1:0]  below_r, below_nxt;
  logic        first_r, first_nxt;
  logic        touch_r, touch_nxt;
  logic        red_r, red_nxt;
  logic        green_r, green_nxt;
  logic        flick;

  // sampling starts once the settle interval has run out and stops when off
  assign sample_req    = ms_tick && (state_r != ST_SETTLE) && (state_r != ST_OFF);
  assign led_red       = red_r;
  assign led_green     = green_r;
  assign touch_out     = touch_r;
  assign probe_present = (state_r != ST_OFF);
  assign power_hold    = (state_r != ST_OFF);
  assign flick         = bl_r[`FLICKER_BIT];

  always_comb begin
    state_nxt = state_r;
    tm_nxt    = ms_tick ? tm_r + 16'h0001 : tm_r;
    bl_nxt    = bl_r;
    ph_nxt    = ph_r;
    hc_nxt    = hc_r;
    min_nxt   = min_r;
    max_nxt   = max_r;
    cref_nxt  = cref_r;
    fref_nxt  = fref_r;
    thr_nxt   = thr_r;
    seen_nxt  = seen_r;
    retry_nxt = retry_r;
    below_nxt = below_r;
    first_nxt = first_r;
    touch_nxt = touch_r;
    red_nxt   = 1'b0;
    green_nxt = 1'b0;
    // slow blink phase and half count
    if (ms_tick) begin
      if (bl_r >= SLOW_HALF_MS - 16'h0001) begin
        bl_nxt = 16'h0000;
        ph_nxt = !ph_r;
        hc_nxt = hc_r + 4'h1;
      end else begin
        bl_nxt = bl_r + 16'h0001;
      end
    end
    case (state_r)
      ST_SETTLE: begin
        if (tm_r >= SETTLE_MS) begin
          state_nxt = batt_s_r ? ST_LOWBAT : ST_LEARN_C;
          min_nxt   = `CODE_FULL;
          seen_nxt  = 1'b0;
        end
      end
      ST_LEARN_C: begin
        green_nxt = seen_r;
        if (sample_valid) begin
          if (sample_code < min_r) begin
            min_nxt = sample_code;
          end
          if (sample_code < `OPEN_LEVEL) begin
            seen_nxt = 1'b1;
          end
        end
        if (tm_r >= CONTACT_WIN_MS) begin
          if (!seen_r) begin
            state_nxt = ST_NOCONTACT;
          end else if (min_r > `POOR_MAX) begin
            state_nxt = ST_POOR;
          end else begin
            cref_nxt  = min_r;
            max_nxt   = `CODE_ZERO;
            retry_nxt = 1'b0;
            state_nxt = ST_LEARN_F;
          end
        end
      end
      ST_LEARN_F: begin
        green_nxt = retry_r && flick;
        if (sample_valid && sample_code > max_r) begin
          max_nxt = sample_code;
        end
        if (tm_r >= FREE_WIN_MS) begin
          if (max_r < cref_r || (max_r - cref_r) < `MIN_SEP) begin
            retry_nxt = 1'b1;
            max_nxt   = `CODE_ZERO;
            tm_nxt    = 16'h0000;
          end else begin
            fref_nxt  = max_r;
            thr_nxt   = mid_code(cref_r, max_r);
            below_nxt = 2'h0;
            first_nxt = 1'b0;
            touch_nxt = 1'b0;
            state_nxt = ST_ARMED;
          end
        end
      end
      ST_ARMED: begin
        red_nxt   = touch_r;
        green_nxt = !touch_r;
        if (sample_valid) begin
          if (sample_code < thr_r) begin
            if (below_r >= `TOUCH_COUNT - 2'h1) begin
              touch_nxt = 1'b1;
              if (!first_r) begin
                first_nxt = 1'b1;
                tm_nxt    = 16'h0000;
              end
            end else begin
              below_nxt = below_r + 2'h1;
            end
          end else if (sample_code > thr_r) begin
            below_nxt = 2'h0;
            touch_nxt = 1'b0;
          end
        end
        if (tm_r >= ARM_TIMEOUT_MS) begin
          if (!first_r) begin
            state_nxt = ST_CRASH;
            touch_nxt = 1'b1;
          end else if (!stay_s_r) begin
            state_nxt = ST_OFF;
          end else begin
            tm_nxt = tm_r;
          end
        end
      end
      ST_CRASH: begin
        touch_nxt = 1'b1;
        red_nxt   = ph_r;
        green_nxt = !ph_r;
        if (tm_r >= CRASH_MS) begin
          state_nxt = ST_OFF;
        end
      end
      ST_LOWBAT: begin
        red_nxt   = ph_r;
        green_nxt = !ph_r;
        if (tm_r >= LOWBAT_MS) begin
          state_nxt = ST_OFF;
        end
      end
      ST_NOCONTACT: begin
        green_nxt = flick;
        if (tm_r >= NOCONTACT_MS) begin
          state_nxt = ST_OFF;
        end
      end
      ST_POOR: begin
        // no extra flash on the exit cycle
        red_nxt = !ph_r && (hc_r < `POOR_HALVES);
        if (hc_r >= `POOR_HALVES) begin
          state_nxt = ST_OFF;
        end
      end
      ST_OFF: begin
        touch_nxt = 1'b0;
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    // timers and blink restart with each new state
    if (state_nxt != state_r) begin
      tm_nxt = 16'h0000;
      bl_nxt = 16'h0000;
      ph_nxt = 1'b0;
      hc_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_SETTLE;
      tm_r    <= 16'h0000;
      bl_r    <= 16'h0000;
      ph_r    <= 1'b0;
      hc_r    <= 4'h0;
      min_r   <= `CODE_FULL;
      max_r   <= `CODE_ZERO;
      cref_r  <= `CODE_ZERO;
      fref_r  <= `CODE_ZERO;
      thr_r   <= `CODE_ZERO;
      seen_r  <= 1'b0;
      retry_r <= 1'b0;
      below_r <= 2'h0;
      first_r <= 1'b0;
      touch_r <= 1'b0;
      red_r   <= 1'b0;
      green_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tm_r    <= tm_nxt;
      bl_r    <= bl_nxt;
      ph_r    <= ph_nxt;
      hc_r    <= hc_nxt;
      min_r   <= min_nxt;
      max_r   <= max_nxt;
      cref_r  <= cref_nxt;
      fref_r  <= fref_nxt;
      thr_r   <= thr_nxt;
      seen_r  <= seen_nxt;
      retry_r <= retry_nxt;
      below_r <= below_nxt;
      first_r <= first_nxt;
      touch_r <= touch_nxt;
      red_r   <= red_nxt;
      green_r <= green_nxt;
    end
  end

  // checks
  sequence s_armed_below;
    state_r == ST_ARMED && sample_valid && sample_code < thr_r;
  endsequence

  sequence s_second_below;
    s_armed_below and below_r >= `TOUCH_COUNT - 2'h1;
  endsequence

  property p_settle;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_SETTLE) |-> !sample_req && tm_r <= SETTLE_MS;
  endproperty
  a_settle: assert property (p_settle) else $error("sample taken during settle");

  property p_green_off;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_LEARN_F && $past(state_r) == ST_LEARN_F && !$past(retry_r)) |-> !led_green;
  endproperty
  a_green_off: assert property (p_green_off) else $error("green lit after contact learned");

  property p_threshold;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_ARMED) |-> thr_r == mid_code(cref_r, fref_r) && fref_r >= cref_r;
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold not midpoint");

  property p_armed_green;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_ARMED && $past(state_r) == ST_ARMED && !$past(touch_r))
        |-> led_green && !led_red;
  endproperty
  a_armed_green: assert property (p_armed_green) else $error("armed but not green");

  property p_touch;
    @(posedge clk_sys) disable iff (!rst_b)
      s_second_below ##1 (state_r == ST_ARMED) |-> touch_out ##1 led_red;
  endproperty
  a_touch: assert property (p_touch) else $error("touch not reported");

  property p_release;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_ARMED && sample_valid && sample_code > thr_r && tm_r < ARM_TIMEOUT_MS)
        |=> !touch_out ##1 (led_green || state_r != ST_ARMED);
  endproperty
  a_release: assert property (p_release) else $error("touch not released");

  property p_autooff;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_ARMED && first_r && tm_r >= ARM_TIMEOUT_MS)
        |=> (state_r == (stay_s_r ? ST_ARMED : ST_OFF)) || $past(stay_s_r) != stay_s_r;
  endproperty
  a_autooff: assert property (p_autooff) else $error("auto power down wrong");

  property p_crash;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_ARMED && !first_r && tm_r >= ARM_TIMEOUT_MS)
        |=> state_r == ST_CRASH && touch_out [*3];
  endproperty
  a_crash: assert property (p_crash) else $error("no crash protection");

  property p_timed_off;
    @(posedge clk_sys) disable iff (!rst_b)
      ((state_r == ST_LOWBAT && tm_r >= LOWBAT_MS) ||
       (state_r == ST_NOCONTACT && tm_r >= NOCONTACT_MS)) |=> state_r == ST_OFF;
  endproperty
  a_timed_off: assert property (p_timed_off) else $error("timed power off missed");

  property p_poor;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_POOR && $past(state_r) == ST_POOR) |-> hc_r <= `POOR_HALVES && !led_green;
  endproperty
  a_poor: assert property (p_poor) else $error("poor contact flash count exceeded");

  property p_off;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_r == ST_OFF) |-> !probe_present && !power_hold;
  endproperty
  a_off: assert property (p_off) else $error("present while off");

endmodule : touch_probe_detector
`default_nettype wire

// file: testbench/adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module adc_model
  import touch_probe_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  // converter handshake
  input  wire logic                   sample_req,
  input  wire touch_probe_pkg::code_t level,
  output logic                        sample_valid,
  output touch_probe_pkg::code_t      sample_code
);
  // answers one cycle after a request; code scrambles outside the valid cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sample_valid <= 1'b0;
      sample_code  <= 10'h000;
    end else if (sample_req) begin
      sample_valid <= 1'b1;
      sample_code  <= level;
    end else begin
      sample_valid <= 1'b0;
      sample_code  <= ~sample_code;
    end
  end
endmodule : adc_model
`default_nettype wire

// file: testbench/touch_probe_detector_bench.sv
`timescale 1ns/100ps
`default_nettype none
module touch_probe_detector_bench;
  import touch_probe_pkg::*;
  logic  clk_sys, rst_b, batt_low, stay_awake, sample_req, sample_valid;
  logic  led_red, led_green, touch_out, probe_present, power_hold, red_q, grn_q;
  code_t level, sample_code;
  int    errors, check_count, red_up, grn_up, r0, g0, n;
  wire logic [3:0] outs = {power_hold, touch_out, led_red, led_green};

  touch_probe_detector #(
    .TICK_CYCLES(1), .ARM_TIMEOUT_MS(16'h0064), .LOWBAT_MS(16'h0600),
    .NOCONTACT_MS(16'h0600), .CRASH_MS(16'h0600)
  ) DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .sample_req(sample_req),
    .sample_code(sample_code), .sample_valid(sample_valid), .batt_low(batt_low),
    .stay_awake(stay_awake), .led_red(led_red), .led_green(led_green),
    .touch_out(touch_out), .probe_present(probe_present), .power_hold(power_hold)
  );

  adc_model adc (
    .clk_sys(clk_sys), .rst_b(rst_b), .sample_req(sample_req), .level(level),
    .sample_valid(sample_valid), .sample_code(sample_code)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // rising edges of each colour
  always @(posedge clk_sys) begin
    red_q <= led_red;
    grn_q <= led_green;
    if (led_red === 1'b1 && red_q === 1'b0) red_up++;
    if (led_green === 1'b1 && grn_q === 1'b0) grn_up++;
  end

  task automatic chk(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp, input string m);
    check_count++;
    if (got != exp) begin
      errors++;
      $display("mismatch at %0t: %s got %0d", $time, m, got);
    end
  endtask : chk_n

  task automatic wt(input logic [3:0] m, input logic [3:0] v, input int lim, input string s);
    n = 0;
    while ((outs & m) !== v && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n < lim, 1'b1, s);
  endtask : wt

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic rst(input logic bl, input code_t l);
    @(posedge clk_sys);
    rst_b      <= 1'b0;
    batt_low   <= bl;
    level      <= l;
    stay_awake <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(outs === 4'b1000 && probe_present === 1'b1, 1'b1, "reset outputs");
    @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    r0 = red_up;
    g0 = grn_up;
  endtask : rst

  // one sample per clock: the level stands until the next call
  task automatic one_sample(input code_t v);
    chk(probe_present, 1'b1, "present while powered");
    @(posedge clk_sys);
    level <= v;
    #1;
  endtask : one_sample

  task automatic arm(input code_t cref, input code_t fref);
    rst(1'b0, cref);
    wt(4'b0001, 4'b0001, 700, "green on with bridge");
    wt(4'b0001, 4'b0000, 1100, "green off after contact");
    @(posedge clk_sys);
    level <= fref;
    #1;
  endtask : arm

  task automatic t_sunny;
    rst(1'b0, 10'h050);
    n = 0;
    while (sample_req !== 1'b1 && n < 600) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n >= 500 && n < 510, 1'b1, "settle before first sample");
    wt(4'b0001, 4'b0001, 200, "green on with bridge");
    wt(4'b0001, 4'b0000, 1100, "green off after contact");
    @(posedge clk_sys);
    level <= 10'h300;
    stay_awake <= 1'b1;
    wt(4'b0101, 4'b0001, 1100, "armed green");
    one_sample(10'h100);
    one_sample(10'h300);
    cyc(20);
    chk(touch_out, 1'b0, "single low sample");
    one_sample(10'h100);
    wt(4'b0100, 4'b0100, 40, "touch after two low");
    cyc(2);
    chk(outs === 4'b1110, 1'b1, "red on touch");
    one_sample(10'h3A0);
    wt(4'b0100, 4'b0000, 40, "touch released");
    cyc(2);
    chk(outs === 4'b1001, 1'b1, "green after release");
    one_sample(10'h100);
    cyc(150);
    chk(power_hold, 1'b1, "stay awake holds power");
    @(posedge clk_sys);
    stay_awake <= 1'b0;
    wt(4'b1000, 4'b0000, 40, "power down after touch");
    chk(probe_present, 1'b0, "present drops when off");
  endtask : t_sunny

  task automatic t_crash;
    arm(10'h050, 10'h300);
    wt(4'b0001, 4'b0001, 1100, "armed green");
    r0 = red_up;
    g0 = grn_up;
    wt(4'b0100, 4'b0100, 200, "crash touch");
    wt(4'b1000, 4'b0000, 1700, "crash power down");
    chk(red_up > r0 && grn_up > g0, 1'b1, "crash alternation");
  endtask : t_crash

  task automatic t_faults;
    rst(1'b1, 10'h050);
    wt(4'b1000, 4'b0000, 2200, "low battery off");
    chk(red_up > r0 && grn_up > g0, 1'b1, "low battery alternation");
    rst(1'b0, 10'h0D0);
    wt(4'b1000, 4'b0000, 7000, "poor contact off");
    chk_n(red_up - r0, 5, "poor contact flashes");
    rst(1'b0, 10'h3FF);
    wt(4'b1000, 4'b0000, 3300, "no contact off");
    chk(grn_up - g0 >= 2, 1'b1, "no contact flicker");
    arm(10'h050, 10'h052);
    g0 = grn_up;
    cyc(1400);
    chk(grn_up - g0 >= 2 && power_hold === 1'b1, 1'b1, "free too small flicker");
  endtask : t_faults

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done;
  end

  initial begin
    rst_b = 1'b0;
    batt_low = 1'b0;
    stay_awake = 1'b0;
    level = 10'h000;
    errors = 0;
    check_count = 0;
    red_up = 0;
    grn_up = 0;
    t_sunny;
    t_crash;
    t_faults;
    test_done;
  end
endmodule : touch_probe_detector_bench
`default_nettype wire
